//--- src/irm_defines.svh
// Offsets, field positions and reset values of the interrupt routing block
`ifndef IRM_DEFINES_SVH
`define IRM_DEFINES_SVH
`define IRM_ROUTE_OFFSET 8'hc0
`define IRM_ROUTE_RESET 8'h00
`define IRM_BIT_PARALLEL 0
`define IRM_BIT_RTC_PIN 1
`define IRM_BIT_SCI_PIN 2
`define IRM_BIT_SCI_HIGH 3
`define IRM_BIT_SCI_OD 4
`define IRM_SHARED_LO 5
`define IRM_SHARED_HI 6
`define IRM_BIT_SMI_PIN 7
`define IRM_SMI_SLOT 4'h2
`endif

//--- src/irm_pkg.sv
// Types of the interrupt routing block
package irm_pkg;
    // Shared pin function codes
    typedef enum logic [1:0] {
        IRM_SHARED_PME = 2'h0,
        IRM_SHARED_SCI = 2'h1,
        IRM_SHARED_IRQ9 = 2'h2,
        IRM_SHARED_RSVD = 2'h3
    } irm_shared_t;
    // Bus slave data phase states
    typedef enum logic [1:0] {
        IRM_IDLE,
        IRM_WRITE,
        IRM_READ
    } irm_phase_t;
endpackage : irm_pkg

//--- src/irm_cfg_if.sv
// Routing configuration carried from the register to the routing decode
`timescale 1ns/1ps
interface irm_cfg_if;
    logic [7:0] route;
    modport source (output route);
    modport sink (input route);
endinterface : irm_cfg_if

//--- src/irm_pin_drive.sv
// Driver of one interrupt pin with selectable polarity and buffer type
`timescale 1ns/1ps
module irm_pin_drive (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic active,
    input wire logic high_true,
    input wire logic open_drain,
    // Pin
    output logic pin_o,
    output logic pin_oe_n
);
    logic next_pin_o;
    logic next_pin_oe_n;

    // Open drain only pulls low; a high level is left to the pull-up
    always_comb begin
        next_pin_o = active ~^ high_true;
        next_pin_oe_n = 1'b0;
        if (open_drain) begin
            next_pin_o = 1'b0;
            next_pin_oe_n = active ~^ high_true; // Released when the level is high
        end
    end

    // Register pin outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_o <= 1'b1;
            pin_oe_n <= 1'b1;
        end else begin
            pin_o <= next_pin_o;
            pin_oe_n <= next_pin_oe_n;
        end
    end
endmodule : irm_pin_drive

//--- src/irm_route_top.sv
// Interrupt routing control register with AHB-Lite slave and routing logic
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`include "irm_defines.svh"
module irm_route_top
    import irm_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt sources
    input wire logic [15:0] irq_req,
    input wire logic rtc_irq,
    input wire logic sci_req,
    input wire logic smi_req,
    input wire logic pme_req,
    input wire logic [3:0] sci_cfg_irq,
    input wire logic standby_supply,
    // SMI pin configuration from general purpose pin logic
    input wire logic smi_high_true,
    input wire logic smi_open_drain,
    // Serial frame request vector, parallel pins and RTC/SCI routing outputs
    output logic [15:0] serial_frame_req,
    output logic serial_enable,
    output logic bios_buffer_enable,
    output logic [15:0] parallel_irq,
    output logic rtc_irq_pin,
    output logic [3:0] sci_irq_number,
    // SCI pin
    output logic sci_pin_o,
    output logic sci_pin_oe_n,
    // Shared pin
    output logic shared_pin_o,
    output logic shared_pin_oe_n,
    // Dedicated SMI pin
    output logic system_mgmt_interrupt_pin_o,
    output logic system_mgmt_interrupt_pin_oe_n
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    irm_phase_t phase; // Data phase kind
    irm_phase_t next_phase;
    logic [7:0] route; // Routing register
    logic [7:0] next_route;
    logic [31:0] next_hrdata;
    logic hit; // Address matches register
    logic start; // Valid address phase

    assign start = hsel && htrans[1];
    assign hit = (haddr[7:0] == `IRM_ROUTE_OFFSET) && (haddr[31:8] == 24'h000000);

    // Next state of bus slave and register
    always_comb begin
        next_phase = IRM_IDLE;
        next_route = route;
        next_hrdata = 32'h00000000;
        if (phase == IRM_WRITE) begin
            next_route = hwdata[7:0];
        end
        if (start) begin
            if (!hwrite) begin
                next_phase = IRM_READ;
                // Unmapped reads return zero
                next_hrdata = hit ? {24'h000000, next_route} : 32'h00000000;
            end else if (hit) begin
                next_phase = IRM_WRITE;
            end
        end
    end

    // Register bus state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= IRM_IDLE;
            route <= `IRM_ROUTE_RESET;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            phase <= next_phase;
            route <= next_route;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Routing decode
    // ------------------------------------------------------------
    irm_cfg_if cfg ();
    assign cfg.route = route;

    logic par_mode; // Parallel pins in use
    logic rtc_pin; // RTC on its pin
    logic sci_pin; // SCI on its pin
    logic smi_pin; // SMI on its pin
    irm_shared_t shared; // Shared pin function
    logic [15:0] next_frame;
    logic [15:0] next_par;
    logic [3:0] next_sci_num;
    logic shared_active;
    logic shared_high;
    logic shared_od;
    logic sci_active;

    // Standby supply forces every interrupt onto pins
    assign par_mode = cfg.route[`IRM_BIT_PARALLEL] | standby_supply;
    assign rtc_pin = cfg.route[`IRM_BIT_RTC_PIN] | standby_supply;
    assign sci_pin = cfg.route[`IRM_BIT_SCI_PIN] | standby_supply;
    assign smi_pin = cfg.route[`IRM_BIT_SMI_PIN] | standby_supply;
    assign shared = irm_shared_t'(cfg.route[`IRM_SHARED_HI:`IRM_SHARED_LO]);
    assign sci_active = sci_req & sci_pin;

    // Serial frame and parallel vectors
    always_comb begin
        next_frame = par_mode ? 16'h0000 : irq_req;
        next_par = par_mode ? irq_req : 16'h0000;
        if (!par_mode) begin
            next_frame[8] = 1'b0;
        end
        if (!rtc_pin) begin
            next_frame[8] = rtc_irq;
        end
        if (!sci_pin) begin
            next_frame[sci_irq_sel()] = next_frame[sci_irq_sel()] | sci_req;
        end
        if (!smi_pin) begin
            next_frame[`IRM_SMI_SLOT] = next_frame[`IRM_SMI_SLOT] | smi_req;
        end
        next_sci_num = sci_irq_sel();
    end

    // Low bit of the shared pin code (SCI or reserved code) replaces the configured SCI number with 9
    function automatic logic [3:0] sci_irq_sel();
        sci_irq_sel = cfg.route[`IRM_SHARED_LO] ? 4'h9 : sci_cfg_irq;
    endfunction : sci_irq_sel

    // Shared pin function and driver style
    always_comb begin
        shared_active = 1'b0;
        shared_high = 1'b0;
        shared_od = 1'b1;
        unique case (shared)
            IRM_SHARED_PME: begin
                shared_active = pme_req;
            end
            IRM_SHARED_SCI: begin
                shared_active = sci_active;
                shared_high = cfg.route[`IRM_BIT_SCI_HIGH];
                shared_od = cfg.route[`IRM_BIT_SCI_OD];
            end
            IRM_SHARED_IRQ9: begin
                shared_active = irq_req[9];
                shared_high = 1'b1;
                shared_od = 1'b0;
            end
            default: begin
                shared_active = 1'b0; // Reserved code leaves pin released
            end
        endcase
    end

    // Registered routing outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_frame_req <= 16'h0000;
            serial_enable <= 1'b0;
            bios_buffer_enable <= 1'b0;
            parallel_irq <= 16'h0000;
            rtc_irq_pin <= 1'b0;
            sci_irq_number <= 4'h0;
        end else begin
            serial_frame_req <= next_frame;
            serial_enable <= ~par_mode;
            bios_buffer_enable <= ~par_mode;
            parallel_irq <= next_par;
            rtc_irq_pin <= rtc_irq & rtc_pin;
            sci_irq_number <= next_sci_num;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    irm_pin_drive u_sci (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(sci_active),
        .high_true(cfg.route[`IRM_BIT_SCI_HIGH]),
        .open_drain(cfg.route[`IRM_BIT_SCI_OD]),
        .pin_o(sci_pin_o),
        .pin_oe_n(sci_pin_oe_n)
    );

    irm_pin_drive u_shared (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(shared_active),
        .high_true(shared_high),
        .open_drain(shared_od),
        .pin_o(shared_pin_o),
        .pin_oe_n(shared_pin_oe_n)
    );

    irm_pin_drive u_smi (
        .hclk(hclk),
        .hresetn(hresetn),
        .active(smi_req & smi_pin),
        .high_true(smi_high_true),
        .open_drain(smi_open_drain),
        .pin_o(system_mgmt_interrupt_pin_o),
        .pin_oe_n(system_mgmt_interrupt_pin_oe_n)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Every output is registered, so each check looks one cycle after its cause
    // Mode, standby and parallel outputs
    chk_par_serial: assert property (@(posedge hclk) disable iff (!hresetn)
        (par_mode && !rtc_irq && !sci_req && !smi_req) |=>
        serial_frame_req == 16'h0000 && !serial_enable)
        else $error("serial frame active in parallel mode");
    chk_serial_mode: assert property (@(posedge hclk) disable iff (!hresetn)
        !par_mode |=> serial_enable && parallel_irq == 16'h0000)
        else $error("serial mode outputs wrong");
    chk_par_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        par_mode |=> parallel_irq == $past(irq_req))
        else $error("parallel pins do not follow requests");
    chk_bios_off: assert property (@(posedge hclk) disable iff (!hresetn)
        route[0] |=> !bios_buffer_enable)
        else $error("bios buffer left on");
    chk_standby_pins: assert property (@(posedge hclk) disable iff (!hresetn)
        standby_supply |=> !serial_enable)
        else $error("serial used on standby");
    // Frame slots and dedicated pins
    chk_rtc_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (rtc_irq && rtc_pin) |=> rtc_irq_pin)
        else $error("rtc pin not driven");
    chk_rtc_frame: assert property (@(posedge hclk) disable iff (!hresetn)
        (rtc_irq && !rtc_pin) |=> serial_frame_req[8])
        else $error("rtc missing from frame");
    chk_sci_frame: assert property (@(posedge hclk) disable iff (!hresetn)
        (sci_req && !sci_pin) |=> serial_frame_req[sci_irq_number])
        else $error("sci missing from frame");
    chk_smi_frame: assert property (@(posedge hclk) disable iff (!hresetn)
        (smi_req && !smi_pin) |=> serial_frame_req[`IRM_SMI_SLOT])
        else $error("smi missing from frame");
    chk_sci_override: assert property (@(posedge hclk) disable iff (!hresetn)
        route[5] |=> sci_irq_number == 4'h9)
        else $error("sci number not overridden");
    // Pin driver styles
    chk_sci_pol: assert property (@(posedge hclk) disable iff (!hresetn)
        (sci_active && !route[4]) |=> sci_pin_o == $past(route[3]))
        else $error("sci polarity wrong");
    chk_sci_od: assert property (@(posedge hclk) disable iff (!hresetn)
        (route[4] && sci_active == route[3]) |=> sci_pin_oe_n)
        else $error("open drain sci driving high level");
    chk_irq9_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (shared == IRM_SHARED_IRQ9) |=> !shared_pin_oe_n)
        else $error("irq9 pin not push-pull");
    chk_pme_drive: assert property (@(posedge hclk) disable iff (!hresetn)
        (shared == IRM_SHARED_PME) |=> shared_pin_oe_n == !$past(pme_req))
        else $error("power event pin not low open drain");
    chk_shared_rsvd: assert property (@(posedge hclk) disable iff (!hresetn)
        (shared == IRM_SHARED_RSVD) |=> shared_pin_oe_n)
        else $error("reserved shared code drives pin");
    chk_smi_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        (smi_req && smi_pin && !smi_high_true && smi_open_drain) |=>
        !system_mgmt_interrupt_pin_o && !system_mgmt_interrupt_pin_oe_n)
        else $error("smi pin not pulled low");
    // Register bus
    chk_write_back: assert property (@(posedge hclk) disable iff (!hresetn)
        phase == IRM_WRITE |=> route == $past(hwdata[7:0]))
        else $error("write not stored");
    chk_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
        (start && !hwrite && hit) |=> hrdata == {24'h000000, route})
        else $error("read data not register value");
endmodule : irm_route_top

//--- tb/irm_host_model.sv
// Host chipset side: pulled-up interrupt lines seen by the far end
`timescale 1ns/1ps
module irm_host_model (
    // SCI pin driver
    input wire logic sci_o,
    input wire logic sci_oe_n,
    // Shared pin driver
    input wire logic shr_o,
    input wire logic shr_oe_n,
    // SMI pin driver
    input wire logic smi_o,
    input wire logic smi_oe_n,
    // Resolved line levels
    output logic sci_line,
    output logic shr_line,
    output logic smi_line
);
    // Released lines rise to the board pull-up
    assign sci_line = sci_oe_n ? 1'b1 : sci_o;
    assign shr_line = shr_oe_n ? 1'b1 : shr_o;
    assign smi_line = smi_oe_n ? 1'b1 : smi_o;
endmodule : irm_host_model

//--- tb/tb.sv
// Self-checking bench of the interrupt routing block
`timescale 1ns/1ps
`include "irm_defines.svh"
module tb;
    // Bus side
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp;
    // Sources and pins
    logic [15:0] irq_req = 16'h0, serial_frame_req, parallel_irq;
    logic rtc_irq = 1'b0, sci_req = 1'b0, smi_req = 1'b0, pme_req = 1'b0;
    logic [3:0] sci_cfg_irq = 4'h5, sci_irq_number;
    logic standby_supply = 1'b0, smi_high_true = 1'b0, smi_open_drain = 1'b1;
    logic serial_enable, bios_buffer_enable, rtc_irq_pin;
    logic sci_o, sci_oe_n, shr_o, shr_oe_n, smi_o, smi_oe_n;
    logic sci_line, shr_line, smi_line;
    // Counters
    int err_count = 0, checks = 0, cyc = 0;
    localparam logic [31:0] OFS = {24'h0, `IRM_ROUTE_OFFSET};

    // 25 MHz clock
    always #20 hclk = ~hclk;

    irm_route_top i_irm_route_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq_req(irq_req), .rtc_irq(rtc_irq), .sci_req(sci_req),
        .smi_req(smi_req), .pme_req(pme_req), .sci_cfg_irq(sci_cfg_irq),
        .standby_supply(standby_supply), .smi_high_true(smi_high_true),
        .smi_open_drain(smi_open_drain), .serial_frame_req(serial_frame_req),
        .serial_enable(serial_enable), .bios_buffer_enable(bios_buffer_enable),
        .parallel_irq(parallel_irq), .rtc_irq_pin(rtc_irq_pin),
        .sci_irq_number(sci_irq_number), .sci_pin_o(sci_o), .sci_pin_oe_n(sci_oe_n),
        .shared_pin_o(shr_o), .shared_pin_oe_n(shr_oe_n),
        .system_mgmt_interrupt_pin_o(smi_o),
        .system_mgmt_interrupt_pin_oe_n(smi_oe_n));

    irm_host_model i_irm_host_model (
        .sci_o(sci_o), .sci_oe_n(sci_oe_n), .shr_o(shr_o), .shr_oe_n(shr_oe_n),
        .smi_o(smi_o), .smi_oe_n(smi_oe_n), .sci_line(sci_line),
        .shr_line(shr_line), .smi_line(smi_line));

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wait_rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_rdy

    // One single word transfer, address phase then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    // Write routing register and let outputs settle
    task automatic setr(input logic [7:0] v);
        ahb(1'b1, OFS, {24'h0, v});
        repeat (3) @(posedge hclk);
    endtask : setr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        ahb(1'b0, OFS, 32'h0);
        chk(rd, 32'h0, "reset value");
        chk({hresp, hreadyout}, 32'h1, "okay and ready");
        setr(8'ha5);
        ahb(1'b0, OFS, 32'h0);
        chk(rd, 32'ha5, "readback");
        ahb(1'b1, OFS + 32'h4, 32'hff);
        ahb(1'b0, OFS + 32'h4, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        ahb(1'b1, OFS, 32'hffff_ff3c);
        ahb(1'b0, OFS, 32'h0);
        chk(rd, 32'h3c, "upper bits");
        $display("test regs done");
    endtask : t_regs

    task automatic t_mode;
        irq_req <= 16'hc000;
        setr(8'h00);
        chk(serial_enable, 1'b1, "serial on");
        chk(serial_frame_req, 16'hc000, "serial slots");
        chk(bios_buffer_enable, 1'b1, "bios on");
        setr(8'h01);
        chk(serial_enable, 1'b0, "serial off");
        chk(bios_buffer_enable, 1'b0, "bios off");
        chk(parallel_irq[15:14], 2'h3, "irq15 irq14");
        setr(8'h00);
        standby_supply <= 1'b1;
        repeat (3) @(posedge hclk);
        chk(serial_enable, 1'b0, "standby");
        standby_supply <= 1'b0;
        irq_req <= 16'h0;
        $display("test mode done");
    endtask : t_mode

    task automatic t_rtc;
        rtc_irq <= 1'b1;
        setr(8'h02);
        chk(rtc_irq_pin, 1'b1, "rtc pin");
        setr(8'h03);
        chk(rtc_irq_pin, 1'b1, "rtc pin parallel");
        setr(8'h01);
        chk(rtc_irq_pin, 1'b0, "rtc off pin");
        chk(serial_frame_req[8], 1'b1, "rtc slot parallel");
        setr(8'h00);
        chk(serial_frame_req[8], 1'b1, "rtc slot");
        rtc_irq <= 1'b0;
        $display("test rtc done");
    endtask : t_rtc

    task automatic t_smi;
        smi_req <= 1'b1;
        setr(8'h00);
        chk(serial_frame_req[`IRM_SMI_SLOT], 1'b1, "smi slot");
        chk(smi_oe_n, 1'b1, "smi pin idle");
        setr(8'h80);
        chk({smi_line, smi_oe_n}, 2'h0, "smi pin low");
        smi_high_true <= 1'b1;
        smi_open_drain <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({smi_o, smi_oe_n}, 2'h2, "smi push high");
        smi_high_true <= 1'b0;
        smi_open_drain <= 1'b1;
        smi_req <= 1'b0;
        $display("test smi done");
    endtask : t_smi

    task automatic t_sci;
        logic [7:0] cfg [6] = '{8'h04, 8'h0c, 8'h14, 8'h1c, 8'h14, 8'h04};
        logic [1:0] exp [6] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2};
        sci_req <= 1'b1;
        setr(8'h00);
        chk(serial_frame_req[5], 1'b1, "sci slot");
        chk({sci_line, sci_oe_n}, 2'h2, "sci pin idle");
        for (int i = 0; i < 6; i++) begin
            if (i == 4) begin
                sci_req <= 1'b0;
            end
            setr(cfg[i]);
            chk({sci_line, sci_oe_n}, exp[i], "sci pin");
        end
        $display("test sci done");
    endtask : t_sci

    task automatic t_shared;
        logic [1:0] exp [4] = '{2'h3, 2'h0, 2'h2, 2'h3};
        logic [3:0] num [4] = '{4'h5, 4'h9, 4'h5, 4'h9};
        sci_req <= 1'b1;
        irq_req <= 16'h0200;
        for (int i = 0; i < 4; i++) begin
            setr({1'b0, i[1:0], 5'h04});
            chk({shr_line, shr_oe_n}, exp[i], "shared pin");
            chk(sci_irq_number, num[i], "sci number");
        end
        $display("test shared done");
    endtask : t_shared

    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_mode();
        t_rtc();
        t_smi();
        t_sci();
        t_shared();
        end_sim();
    end
endmodule : tb
